// file: verilog/prpi_pkg.sv
// Shared constants for the management link, reset pulse and shared pin.
// Assumes a 20 MHz system clock on both ends.
package prpi_pkg;
   localparam int          SYS_PERIOD_NS = 50;
   localparam int          MDC_MAX_MHZ   = 25;
   localparam int          MDC_HALF_CYC  = 4;
   localparam int          RST_MIN_NS    = 1000;
   localparam int          RST_HOLD_CYC  = (RST_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam logic [5:0]  PRE_LEN       = 6'h20;
   localparam logic [4:0]  HDR_LAST      = 5'h0c;
   localparam logic [4:0]  DATA_LEN      = 5'h10;
   localparam logic [4:0]  TA_LAST       = 5'h01;
   localparam logic [6:0]  FRAME_LEN     = 7'h40;
   localparam logic [6:0]  RD_RELEASE    = 7'h2e;
   localparam logic [6:0]  RD_FIRST      = 7'h31;
   localparam logic [1:0]  FRAME_START   = 2'h1;
   localparam logic [1:0]  OP_RD         = 2'h2;
   localparam logic [1:0]  OP_WR         = 2'h1;
   localparam logic [1:0]  TA_WR_BITS    = 2'h2;
   localparam logic [31:0] PREAMBLE      = 32'hffffffff;
   localparam logic [4:0]  DEV_PHY_ADDR  = 5'h01;
   localparam logic [4:0]  REG_CTRL      = 5'h00;
   localparam logic [4:0]  REG_STAT      = 5'h01;
   localparam logic [4:0]  REG_PINCFG    = 5'h11;
   localparam int          CTRL_PD_BIT   = 11;
   localparam int          PINCFG_IRQ    = 0;
   localparam int          STAT_SLEEP    = 0;
   localparam int          STAT_IRQ      = 1;
   localparam int          STAT_IRQ_MODE = 2;
   localparam logic [2:0]  MDC_DIV_LAST  = 3'(MDC_HALF_CYC - 1);
   localparam logic [4:0]  RST_HOLD      = 5'(RST_HOLD_CYC);

   typedef enum logic [2:0] {
      DEV_PRE   = 3'h0,
      DEV_HDR   = 3'h1,
      DEV_TA_RD = 3'h2,
      DEV_RD    = 3'h3,
      DEV_TA_WR = 3'h4,
      DEV_WR    = 3'h5
   } prpi_dev_st_t;

   typedef enum logic [1:0] {
      STA_IDLE = 2'h0,
      STA_WAIT = 2'h1,
      STA_RUN  = 2'h2
   } prpi_sta_st_t;
endpackage : prpi_pkg

// file: verilog/prpi_mgmt_if.sv
// Management link between station and device: clock, data line, reset, shared pin.
// Resolves the pulled-up data line and the open-drain shared pin from the enables.
`timescale 1ns/100ps
interface prpi_mgmt_if;
   logic mdc;
   logic phy_rst_n;
   logic st_mdio_out;
   logic st_mdio_oe;
   logic dev_mdio_out;
   logic dev_mdio_oe;
   logic mdio;
   logic st_pin_out;
   logic st_pin_oe;
   logic dev_pin_out;
   logic dev_pin_oe;
   logic pin;

   // Pull-up wins when nobody drives
   assign mdio = st_mdio_oe ? st_mdio_out : (dev_mdio_oe ? dev_mdio_out : 1'b1);
   assign pin  = (st_pin_oe && !st_pin_out) || (dev_pin_oe && !dev_pin_out) ? 1'b0 : 1'b1;

   modport dev (
      input  mdc, phy_rst_n, mdio, pin,
      output dev_mdio_out, dev_mdio_oe, dev_pin_out, dev_pin_oe
   );
   modport sta (
      input  mdio, pin,
      output mdc, phy_rst_n, st_mdio_out, st_mdio_oe, st_pin_out, st_pin_oe
   );
endinterface : prpi_mgmt_if

// file: verilog/prpi_sta.sv
// Management station end: divides clk_sys into the link clock, runs frames,
// issues the device reset pulse and drives the shared pin low on request.
// Assumes user requests on clk_sys; the link faces prpi_mgmt_if.sta.
`timescale 1ns/100ps
module prpi_sta
   import prpi_pkg::*;
(
   input  wire logic        clk_sys,    // System clock, 20 MHz
   input  wire logic        nrst,       // Async reset, low
   input  wire logic        cmd_valid,  // Frame request
   input  wire logic        cmd_write,  // 1 write, 0 read
   input  wire logic [4:0]  cmd_phy,    // Target address
   input  wire logic [4:0]  cmd_reg,    // Register number
   input  wire logic [15:0] cmd_wdata,  // Write data
   output logic             cmd_ready,  // Idle, request taken
   output logic             rsp_valid,  // Frame finished, one cycle
   output logic [15:0]      rsp_rdata,  // Read data
   input  wire logic        sleep_req,  // Hold shared pin low
   output logic             irq_seen,   // Shared pin seen low, forced low while sleep_req
   input  wire logic        reset_req,  // Start a device reset pulse
   output logic             reset_busy, // Reset pulse running
   prpi_mgmt_if.sta         link        // Link side
);
   logic [2:0]   div_cnt;
   logic         tick;
   logic         fall_evt;
   logic         rise_evt;
   logic [63:0]  frame_sr;
   logic [6:0]   idx;
   logic         is_wr;
   logic [15:0]  rd_sr;
   logic         mdio_m;
   logic         mdio_s;
   logic         pin_m;
   logic         pin_s;
   logic [4:0]   rst_cnt;
   prpi_sta_st_t state;

   assign tick     = (div_cnt == MDC_DIV_LAST);
   assign fall_evt = tick && link.mdc;
   assign rise_evt = tick && !link.mdc;

   // Divide by eight keeps the link clock at 2.5 MHz, far below the ceiling
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         div_cnt  <= 3'h0;
         link.mdc <= 1'b0;
      end else if (tick) begin
         div_cnt  <= 3'h0;
         link.mdc <= !link.mdc;
      end else begin
         div_cnt <= div_cnt + 3'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mdio_m <= 1'b1;
         mdio_s <= 1'b1;
         pin_m  <= 1'b1;
         pin_s  <= 1'b1;
      end else begin
         mdio_m <= link.mdio;
         mdio_s <= mdio_m;
         pin_m  <= link.pin;
         pin_s  <= pin_m;
      end
   end

   // Bits change on the falling edge so the device samples mid-bit
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state            <= STA_IDLE;
         frame_sr         <= 64'h0;
         idx              <= 7'h0;
         is_wr            <= 1'b0;
         cmd_ready        <= 1'b0;
         rsp_valid        <= 1'b0;
         link.st_mdio_out <= 1'b1;
         link.st_mdio_oe  <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (state)
            STA_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  is_wr     <= cmd_write;
                  frame_sr  <= {PREAMBLE, FRAME_START, cmd_write ? OP_WR : OP_RD,
                                cmd_phy, cmd_reg, 2'h2, cmd_write ? cmd_wdata : 16'hffff};
                  idx       <= 7'h0;
                  state     <= STA_WAIT;
               end
            end
            STA_WAIT: begin
               if (fall_evt) begin
                  state <= STA_RUN;
               end
            end
            STA_RUN: begin
               if (fall_evt) begin
                  if (idx == FRAME_LEN) begin
                     link.st_mdio_oe <= 1'b0;
                     rsp_valid       <= 1'b1;
                     state           <= STA_IDLE;
                  end else begin
                     link.st_mdio_out <= frame_sr[63];
                     link.st_mdio_oe  <= is_wr || (idx < RD_RELEASE);
                     frame_sr         <= {frame_sr[62:0], 1'b0};
                     idx              <= idx + 7'h1;
                  end
               end
            end
            default: begin
               state <= STA_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_sr     <= 16'h0;
         rsp_rdata <= 16'h0;
      end else begin
         if (state == STA_RUN && rise_evt && !is_wr && idx >= RD_FIRST) begin
            rd_sr <= {rd_sr[14:0], mdio_s};
         end
         if (state == STA_RUN && fall_evt && idx == FRAME_LEN) begin
            rsp_rdata <= is_wr ? 16'h0 : rd_sr;
         end
      end
   end

   // Pulse starts at reset and on request, always at least the minimum width
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_cnt        <= RST_HOLD;
         link.phy_rst_n <= 1'b0;
         reset_busy     <= 1'b1;
      end else begin
         if (reset_req) begin
            rst_cnt <= RST_HOLD;
         end else if (rst_cnt != 5'h0) begin
            rst_cnt <= rst_cnt - 5'h1;
         end
         link.phy_rst_n <= !reset_req && (rst_cnt == 5'h0);
         reset_busy     <= reset_req || (rst_cnt != 5'h0);
      end
   end

   // Open-drain: pulls the shared pin low only, never high
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         link.st_pin_out <= 1'b0;
         link.st_pin_oe  <= 1'b0;
         irq_seen        <= 1'b0;
      end else begin
         link.st_pin_out <= 1'b0;
         link.st_pin_oe  <= sleep_req;
         irq_seen        <= !pin_s && !sleep_req;
      end
   end
endmodule : prpi_sta

// file: verilog/prpi_dev.sv
// Device end: management frame slave on the link clock, mode registers,
// and the shared power-down / interrupt pin on clk_sys.
// Assumes the station keeps the link clock within limits and drives the reset pulse.
`timescale 1ns/100ps
// Function
// - Station keeps link clock at most 25 MHz
// - Link clock is its own clock domain
// - Only one party drives the data line
// - Shared pin starts as power-down input after reset
// - Pin low in power-down role means sleep
// - Management access keeps working while asleep
// - Interrupt pulls pin low, never high
// - Software selects interrupt role by register write
// - Reset returns all registers to defaults
// - Reset held low at least one microsecond
module prpi_dev
   import prpi_pkg::*;
(
   input  wire logic clk_sys,      // System clock, 20 MHz
   input  wire logic nrst,         // Async reset, low
   input  wire logic irq_event,    // Internal interrupt pending, level
   output logic      sleep_active, // Minimum-power state
   output logic      irq_mode,     // Shared pin in interrupt role
   prpi_mgmt_if.dev  link          // Link side
);
   logic         rst_n;
   prpi_dev_st_t state;
   logic [5:0]   ones_cnt;
   logic [4:0]   bit_cnt;
   logic [12:0]  hdr;
   logic [12:0]  next_hdr;
   logic [15:0]  data_sr;
   logic [15:0]  next_data;
   logic [4:0]   reg_sel;
   logic         hdr_done;
   logic         wr_commit;
   logic [15:0]  rd_word;

   logic         ctrl_pd;
   logic         pin_irq_sel;

   logic         sleep_m;
   logic         sleep_l;
   logic         irq_m;
   logic         irq_l;

   logic         pin_m;
   logic         pin_s;
   logic         sel_m;
   logic         sel_s;
   logic         pd_m;
   logic         pd_s;

   // Either reset source clears both domains to defaults
   assign rst_n = nrst && link.phy_rst_n;

   assign next_hdr  = {hdr[11:0], link.mdio};
   assign next_data = {data_sr[14:0], link.mdio};
   assign hdr_done  = (state == DEV_HDR) && (bit_cnt == HDR_LAST);
   assign wr_commit = (state == DEV_WR) && (bit_cnt == DATA_LEN - 5'h1);

   always_comb begin
      rd_word = 16'h0;
      case (next_hdr[4:0])
         REG_CTRL: begin
            rd_word[CTRL_PD_BIT] = ctrl_pd;
         end
         REG_STAT: begin
            rd_word[STAT_SLEEP]    = sleep_l;
            rd_word[STAT_IRQ]      = irq_l;
            rd_word[STAT_IRQ_MODE] = pin_irq_sel;
         end
         REG_PINCFG: begin
            rd_word[PINCFG_IRQ] = pin_irq_sel;
         end
         default: begin
            rd_word = 16'h0;
         end
      endcase
   end

   // Frame logic runs only on link clock edges, so any slower or stopped clock is fine
   always_ff @(posedge link.mdc or negedge rst_n) begin
      if (!rst_n) begin
         state    <= DEV_PRE;
         ones_cnt <= 6'h0;
         bit_cnt  <= 5'h0;
         hdr      <= 13'h0;
         data_sr  <= 16'h0;
         reg_sel  <= 5'h0;
      end else begin
         case (state)
            DEV_PRE: begin
               if (link.mdio) begin
                  if (ones_cnt != PRE_LEN) begin
                     ones_cnt <= ones_cnt + 6'h1;
                  end
               end else begin
                  if (ones_cnt == PRE_LEN) begin
                     state   <= DEV_HDR;
                     bit_cnt <= 5'h0;
                  end
                  ones_cnt <= 6'h0;
               end
            end
            DEV_HDR: begin
               hdr     <= next_hdr;
               bit_cnt <= bit_cnt + 5'h1;
               if (hdr_done) begin
                  bit_cnt <= 5'h0;
                  reg_sel <= next_hdr[4:0];
                  data_sr <= rd_word;
                  if (!next_hdr[12] || next_hdr[9:5] != DEV_PHY_ADDR) begin
                     state <= DEV_PRE;
                  end else if (next_hdr[11:10] == OP_RD) begin
                     state <= DEV_TA_RD;
                  end else if (next_hdr[11:10] == OP_WR) begin
                     state <= DEV_TA_WR;
                  end else begin
                     state <= DEV_PRE;
                  end
               end
            end
            DEV_TA_RD: begin
               state <= DEV_RD;
            end
            DEV_RD: begin
               bit_cnt <= bit_cnt + 5'h1;
               data_sr <= {data_sr[14:0], 1'b0};
               if (bit_cnt == DATA_LEN) begin
                  bit_cnt <= 5'h0;
                  state   <= DEV_PRE;
               end
            end
            DEV_TA_WR: begin
               bit_cnt <= bit_cnt + 5'h1;
               if (bit_cnt == TA_LAST) begin
                  bit_cnt <= 5'h0;
                  state   <= DEV_WR;
               end
            end
            DEV_WR: begin
               data_sr <= next_data;
               bit_cnt <= bit_cnt + 5'h1;
               if (wr_commit) begin
                  bit_cnt <= 5'h0;
                  state   <= DEV_PRE;
               end
            end
            default: begin
               state <= DEV_PRE;
            end
         endcase
      end
   end

   // Drive only during the second turnaround bit and read data
   always_ff @(posedge link.mdc or negedge rst_n) begin
      if (!rst_n) begin
         link.dev_mdio_out <= 1'b1;
         link.dev_mdio_oe  <= 1'b0;
      end else begin
         case (state)
            DEV_TA_RD: begin
               link.dev_mdio_out <= 1'b0;
               link.dev_mdio_oe  <= 1'b1;
            end
            DEV_RD: begin
               link.dev_mdio_out <= data_sr[15];
               link.dev_mdio_oe  <= (bit_cnt != DATA_LEN);
            end
            default: begin
               link.dev_mdio_out <= 1'b1;
               link.dev_mdio_oe  <= 1'b0;
            end
         endcase
      end
   end

   // Writes are never gated by the sleep state
   always_ff @(posedge link.mdc or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_pd     <= 1'b0;
         pin_irq_sel <= 1'b0;
      end else if (wr_commit) begin
         if (reg_sel == REG_CTRL) begin
            ctrl_pd <= next_data[CTRL_PD_BIT];
         end
         if (reg_sel == REG_PINCFG) begin
            pin_irq_sel <= next_data[PINCFG_IRQ];
         end
      end
   end

   // Status into the link domain; only valid while the link clock runs
   always_ff @(posedge link.mdc or negedge rst_n) begin
      if (!rst_n) begin
         sleep_m <= 1'b0;
         sleep_l <= 1'b0;
         irq_m   <= 1'b0;
         irq_l   <= 1'b0;
      end else begin
         sleep_m <= sleep_active;
         sleep_l <= sleep_m;
         irq_m   <= irq_event;
         irq_l   <= irq_m;
      end
   end

   // Mode bits and the pin level cross into clk_sys through two flops each
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_m <= 1'b1;
         pin_s <= 1'b1;
         sel_m <= 1'b0;
         sel_s <= 1'b0;
         pd_m  <= 1'b0;
         pd_s  <= 1'b0;
      end else begin
         pin_m <= link.pin;
         pin_s <= pin_m;
         sel_m <= pin_irq_sel;
         sel_s <= sel_m;
         pd_m  <= ctrl_pd;
         pd_s  <= pd_m;
      end
   end

   // Own interrupt drive never counts as a sleep request while in interrupt role
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sleep_active <= 1'b0;
         irq_mode     <= 1'b0;
      end else begin
         sleep_active <= pd_s || (!sel_s && !pin_s);
         irq_mode     <= sel_s;
      end
   end

   // Open-drain: output level fixed low, only the enable moves
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         link.dev_pin_out <= 1'b0;
         link.dev_pin_oe  <= 1'b0;
      end else begin
         link.dev_pin_out <= 1'b0;
         link.dev_pin_oe  <= sel_s && irq_event;
      end
   end
endmodule : prpi_dev

// file: bench/prpi_link_properties.sv
// Concurrent checks on the management link joining station and device.
// Assumes all link signals are sampled on clk_sys; mdc is a divided clk_sys.
`timescale 1ns/100ps
module prpi_link_chk
   import prpi_pkg::*;
(
   input wire logic clk_sys,      // System clock
   input wire logic nrst,         // Async reset, low
   input wire logic mdc,          // Link clock
   input wire logic phy_rst_n,    // Device reset, low
   input wire logic st_mdio_out,  // Station data
   input wire logic st_mdio_oe,   // Station data enable
   input wire logic dev_mdio_out, // Device data
   input wire logic dev_mdio_oe,  // Device data enable
   input wire logic dev_pin_out,  // Device pin level
   input wire logic dev_pin_oe    // Device pin enable
);
   int low_cnt;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Counts sampled-low cycles of the device reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) low_cnt <= 0;
      else if (!phy_rst_n) low_cnt <= low_cnt + 1;
      else low_cnt <= 0;
   end

   sequence mdc_hi_s; mdc[*3] ##1 !mdc; endsequence
   sequence mdc_lo_s; !mdc[*3] ##1 mdc; endsequence
   sequence sta_quiet_s; !st_mdio_oe[*4]; endsequence

   mdc_high_a: assert property ($rose(mdc) |=> mdc_hi_s)
      else $error("link clock high phase wrong");
   mdc_low_a: assert property ($fell(mdc) |=> mdc_lo_s)
      else $error("link clock low phase wrong");
   one_driver_a: assert property (!(st_mdio_oe && dev_mdio_oe))
      else $error("data line driven by both ends");
   rd_turn_a: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_out &&
      !st_mdio_oe && !$past(st_mdio_oe, 3)) else $error("bad read turnaround");
   dev_release_a: assert property ($fell(dev_mdio_oe) |-> sta_quiet_s)
      else $error("station drives right after device release");
   pre_ones_a: assert property ($rose(st_mdio_oe) |-> st_mdio_out[*8])
      else $error("frame does not open with ones");
   sta_setup_a: assert property (st_mdio_oe && $changed(st_mdio_out) |-> $fell(mdc))
      else $error("station data changed off the falling link clock");
   rst_hold_a: assert property ($rose(phy_rst_n) |-> low_cnt >= RST_HOLD_CYC)
      else $error("device reset pulse too short");
   dev_quiet_a: assert property (!phy_rst_n |-> !dev_mdio_oe && !dev_pin_oe)
      else $error("device drives while in reset");
   dev_drain_a: assert property (dev_pin_oe |-> !dev_pin_out)
      else $error("shared pin driven high");
endmodule : prpi_link_chk

// file: bench/tb.sv
// Self-checking bench: station and device joined by the management link.
// Assumes the station makes the link clock and the device reset pulse.
`timescale 1ns/100ps
module tb;
   import prpi_pkg::*;
   logic        clk_sys, nrst, cmd_valid, cmd_write, sleep_req, reset_req, irq_event;
   logic        cmd_ready, rsp_valid, irq_seen, reset_busy, sleep_active, irq_mode;
   logic [4:0]  cmd_reg, cmd_phy, rg;
   logic [15:0] exp_q[$];
   logic [15:0] cmd_wdata, rsp_rdata, wd;
   bit          m_pd, m_sel;
   int          err_count, cmp_count;

   prpi_mgmt_if i_prpi_mgmt_if ();
   prpi_sta i_prpi_sta (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_phy(cmd_phy), .cmd_reg(cmd_reg),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .sleep_req(sleep_req), .irq_seen(irq_seen),
      .reset_req(reset_req), .reset_busy(reset_busy), .link(i_prpi_mgmt_if));
   prpi_dev i_prpi_dev (.clk_sys(clk_sys), .nrst(nrst), .irq_event(irq_event),
      .sleep_active(sleep_active), .irq_mode(irq_mode), .link(i_prpi_mgmt_if));
   prpi_link_chk i_prpi_link_chk (.clk_sys(clk_sys), .nrst(nrst),
      .mdc(i_prpi_mgmt_if.mdc), .phy_rst_n(i_prpi_mgmt_if.phy_rst_n),
      .st_mdio_out(i_prpi_mgmt_if.st_mdio_out), .st_mdio_oe(i_prpi_mgmt_if.st_mdio_oe),
      .dev_mdio_out(i_prpi_mgmt_if.dev_mdio_out),
      .dev_mdio_oe(i_prpi_mgmt_if.dev_mdio_oe),
      .dev_pin_out(i_prpi_mgmt_if.dev_pin_out), .dev_pin_oe(i_prpi_mgmt_if.dev_pin_oe));

   always #25 clk_sys = ~clk_sys;

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic report_and_stop();
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   // Bounded wait; a hang counts as a mismatch
   task automatic wait_for(ref logic sig, input logic lvl);
      int n;
      n = 0;
      while (sig !== lvl && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 2000) err_count++;
   endtask : wait_for

   task automatic frame(input logic wr, input logic [4:0] r, input logic [15:0] d,
                        output logic [15:0] q);
      wait_for(cmd_ready, 1'b1);
      cmd_write = wr;
      cmd_reg   = r;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      wait_for(rsp_valid, 1'b1);
      q = rsp_rdata;
      @(negedge clk_sys);
   endtask : frame

   function automatic logic [15:0] exp_rd(input logic [4:0] r);
      logic [15:0] v;
      v = 16'h0000;
      if (r == REG_CTRL) v[CTRL_PD_BIT] = m_pd;
      if (r == REG_PINCFG) v[PINCFG_IRQ] = m_sel;
      if (r == REG_STAT) begin
         v[STAT_SLEEP]    = m_pd | (~m_sel & sleep_req);
         v[STAT_IRQ]      = irq_event;
         v[STAT_IRQ_MODE] = m_sel;
      end
      return v;
   endfunction : exp_rd

   task automatic wr_reg(input logic [4:0] r, input logic [15:0] d);
      logic [15:0] q;
      frame(1'b1, r, d, q);
      // Frames to another address must leave the model untouched
      if (cmd_phy == DEV_PHY_ADDR && r == REG_CTRL) m_pd = d[CTRL_PD_BIT];
      if (cmd_phy == DEV_PHY_ADDR && r == REG_PINCFG) m_sel = d[PINCFG_IRQ];
      repeat (8) @(negedge clk_sys);
   endtask : wr_reg

   task automatic rd_chk(input logic [4:0] r);
      logic [15:0] q;
      exp_q.push_back(exp_rd(r));
      frame(1'b0, r, 16'h0000, q);
      check(q, exp_q.pop_front());
   endtask : rd_chk

   // Pin crosses two flops; eight cycles covers it
   task automatic chk_pins();
      repeat (8) @(negedge clk_sys);
      check(16'(sleep_active), 16'(m_pd | (~m_sel & sleep_req)));
      check(16'(irq_mode), 16'(m_sel));
      if (!sleep_req) check(16'(irq_seen), 16'(m_sel & irq_event));
   endtask : chk_pins

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      report_and_stop();
   end

   initial begin
      {clk_sys, nrst, cmd_valid, cmd_write, sleep_req, reset_req, irq_event} = 7'h00;
      {cmd_reg, cmd_wdata, m_pd, m_sel, err_count, cmp_count} = '0;
      cmd_phy = DEV_PHY_ADDR;
      void'($urandom(32'hb408));
      repeat (16) @(negedge clk_sys);
      nrst = 1'b1;
      wait_for(reset_busy, 1'b0);
      chk_pins();
      irq_event = 1'b1;
      chk_pins();
      rd_chk(REG_STAT);
      irq_event = 1'b0;
      for (int i = 0; i < 3; i++) begin
         rg = 5'h02 + 5'($urandom_range(13));
         wd = 16'($urandom);
         wr_reg(rg, wd);
         rd_chk(rg);
      end
      sleep_req = 1'b1;
      chk_pins();
      rd_chk(REG_STAT);
      wr_reg(REG_CTRL, 16'h0800);
      sleep_req = 1'b0;
      chk_pins();
      rd_chk(REG_CTRL);
      wr_reg(REG_CTRL, 16'h0000);
      chk_pins();
      // Another address: write ignored, read left to the pull-up
      cmd_phy = DEV_PHY_ADDR ^ 5'(1 + $urandom_range(30));
      wr_reg(REG_CTRL, 16'h0800);
      frame(1'b0, REG_CTRL, 16'h0000, wd);
      check(wd, 16'hffff);
      cmd_phy = DEV_PHY_ADDR;
      rd_chk(REG_CTRL);
      wr_reg(REG_PINCFG, 16'h0001);
      chk_pins();
      sleep_req = 1'b1;
      chk_pins();
      sleep_req = 1'b0;
      irq_event = 1'b1;
      chk_pins();
      rd_chk(REG_STAT);
      irq_event = 1'b0;
      chk_pins();
      wr_reg(REG_CTRL, 16'h0800);
      reset_req = 1'b1;
      @(negedge clk_sys);
      reset_req = 1'b0;
      repeat (2) @(negedge clk_sys);
      wait_for(reset_busy, 1'b0);
      m_pd  = 1'b0;
      m_sel = 1'b0;
      chk_pins();
      rd_chk(REG_PINCFG);
      rd_chk(REG_CTRL);
      report_and_stop();
   end
endmodule : tb
